/* design/ast_pkg.sv */
// Package for the asynchronous serial transceiver: register map, fields,
// reset values and timing constants.
// Assumes a 125 MHz system clock and an AXI4-Lite register bus.
package ast_pkg;

  // Register byte offsets
  localparam logic [4:0] CMD_OFS    = 5'h00;
  localparam logic [4:0] CTRL_OFS   = 5'h04;
  localparam logic [4:0] TXD_OFS    = 5'h08;
  localparam logic [4:0] TXSTA_OFS  = 5'h0C;
  localparam logic [4:0] RXD_OFS    = 5'h10;
  localparam logic [4:0] RXSTA_OFS  = 5'h14;

  // Command register fields
  localparam int CMD_WL   = 0;
  localparam int CMD_PE   = 1;
  localparam int CMD_PM   = 2;
  localparam int CMD_XTAL = 3;
  localparam int CMD_RC   = 4;  // Bits 6:4
  localparam logic [7:0] CMD_RST = 8'h01;

  // Control register fields
  localparam int CTRL_BR   = 0;  // Bits 2:0
  localparam int CTRL_XTX  = 3;
  localparam int CTRL_XRX  = 4;
  localparam int CTRL_ENTX = 5;
  localparam int CTRL_ENRX = 6;
  localparam int CTRL_ECHO = 7;
  localparam logic [7:0] CTRL_RST = 8'h05;

  // Oversampling and divider
  localparam int OVS          = 16;
  localparam int OVS_MID      = 8;
  localparam int CLK_HZ       = 125_000_000;
  localparam int BASE_BAUD_HZ = 1200;
  localparam int XTAL_BAUD_HZ = 300;
  localparam int BASE_DIV     = CLK_HZ / (BASE_BAUD_HZ * OVS);
  localparam int XTAL_DIV     = CLK_HZ / (XTAL_BAUD_HZ * OVS);
  localparam int DIV_W        = 20;  // Room for the slowest range shift

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

/* design/ast_tick_if.sv */
// Interface carrying the oversampling tick and frame format between the
// register core and the transmit and receive engines.
// Assumes one clock domain shared by all three modules.
`timescale 1ns/1ns
interface ast_tick_if;
  logic tick;      // One pulse per sixteenth of a bit
  logic eight_bit; // Word length
  logic par_en;
  logic par_odd;
  modport core (output tick, output eight_bit, output par_en,
                output par_odd);
  modport eng  (input tick, input eight_bit, input par_en, input par_odd);
endinterface

/* design/ast_tx.sv */
// Transmit engine: shifts one frame out from a loaded word.
// Assumes load only while idle; the core gates it on busy.
`timescale 1ns/1ns
module ast_tx
  import ast_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  ast_tick_if.eng         fmt,
  input  wire logic       load,
  input  wire logic [7:0] word,
  output logic            busy,
  output logic            line
);
  logic [9:0] sh_q;
  logic [3:0] nbits_q;
  logic [3:0] ph_q;
  logic       par;

  // Parity over active data bits; odd mode inverts
  assign par = (^(fmt.eight_bit ? word : {1'b0, word[6:0]})) ^ fmt.par_odd;

  // Frame: start, data LSB first, optional parity, stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_q    <= 10'h3FF;
      nbits_q <= 4'h0;
      ph_q    <= 4'h0;
      busy    <= 1'b0;
      line    <= 1'b1;
    end else if (load) begin
      busy    <= 1'b1;
      line    <= 1'b0;
      ph_q    <= 4'h0;
      if (fmt.eight_bit)
        sh_q <= {1'b1, fmt.par_en ? par : 1'b1, word};
      else
        sh_q <= {2'b11, fmt.par_en ? par : 1'b1, word[6:0]};
      nbits_q <= 4'd8 + (fmt.eight_bit ? 4'd1 : 4'd0)
                      + (fmt.par_en ? 4'd1 : 4'd0);
    end else if (busy && fmt.tick) begin
      ph_q <= ph_q + 4'h1;
      if (ph_q == 4'(OVS - 1)) begin
        if (nbits_q == 4'h0) begin
          busy <= 1'b0;
          line <= 1'b1;
        end else begin
          line    <= sh_q[0];
          sh_q    <= {1'b1, sh_q[9:1]};
          nbits_q <= nbits_q - 4'h1;
        end
      end
    end
  end
endmodule

/* design/ast_rx.sv */
// Receive engine: oversampled start detect, data, parity and stop capture.
// Assumes the line input is already synchronised and polarity-corrected.
`timescale 1ns/1ns
module ast_rx
  import ast_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  ast_tick_if.eng         fmt,
  input  wire logic       enable,
  input  wire logic       line,
  output logic            busy,
  output logic            done,
  output logic [7:0]      word,
  output logic            start_err,
  output logic            par_err,
  output logic            frame_err
);
  typedef enum {ST_IDLE, ST_START, ST_BITS, ST_STOP} ast_rxst_t;
  ast_rxst_t  st_q;
  logic [3:0] ph_q;
  logic [3:0] n_q;
  logic [8:0] sh_q;
  logic [3:0] total;
  logic       exp_par;

  assign total   = (fmt.eight_bit ? 4'd8 : 4'd7) + (fmt.par_en ? 4'd1 : 4'd0);
  assign exp_par = (^(fmt.eight_bit ? sh_q[7:0] : {1'b0, sh_q[6:0]}))
                   ^ fmt.par_odd;

  // Sample each bit at its middle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE; ph_q <= 4'h0; n_q <= 4'h0; sh_q <= 9'h000;
      busy <= 1'b0; done <= 1'b0; word <= 8'h00;
      start_err <= 1'b0; par_err <= 1'b0; frame_err <= 1'b0;
    end else begin
      done <= 1'b0;
      case (st_q)
        ST_IDLE: if (enable && !line) begin
          st_q <= ST_START; ph_q <= 4'h0; busy <= 1'b1;
        end
        ST_START: if (fmt.tick) begin
          ph_q <= ph_q + 4'h1;
          if (ph_q == 4'(OVS_MID - 1)) begin
            // Glitch shorter than half a bit flags a start error
            start_err <= line;
            st_q <= ST_BITS; ph_q <= 4'h0; n_q <= 4'h0;
          end
        end
        ST_BITS: if (fmt.tick) begin
          ph_q <= ph_q + 4'h1;
          if (ph_q == 4'(OVS - 1)) begin
            sh_q[n_q] <= line;
            n_q <= n_q + 4'h1;
            if (n_q == total - 4'h1) st_q <= ST_STOP;
          end
        end
        ST_STOP: if (fmt.tick) begin
          ph_q <= ph_q + 4'h1;
          if (ph_q == 4'(OVS - 1)) begin
            done <= 1'b1;
            busy <= 1'b0;
            st_q <= ST_IDLE;
            frame_err <= !line;
            word <= fmt.eight_bit ? sh_q[7:0] : {1'b0, sh_q[6:0]};
            par_err <= fmt.par_en &&
                       (exp_par != (fmt.eight_bit ? sh_q[8] : sh_q[7]));
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule

/* design/ast_top.sv */
// Asynchronous serial transceiver top: AXI4-Lite registers, baud divider,
// line synchroniser, echo and inversion, and both engines.
// Assumes rx_pin is asynchronous to aclk; one outstanding access per channel.
`timescale 1ns/1ns
module ast_top
  import ast_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rx_pin,
  output logic             tx_pin,
  output logic             tx_irq,
  output logic             rx_irq
);
  ast_tick_if fmt ();

  logic [7:0]       cmd_q;
  logic [7:0]       ctrl_q;
  logic [7:0]       txd_q;
  logic             tx_full_q;
  logic [7:0]       rxd_q;
  logic             rx_full_q;
  logic             ovr_q;
  logic             serr_q;
  logic             perr_q;
  logic             ferr_q;
  logic [4:0]       aw_q;
  logic             aw_have_q;
  logic [31:0]      w_q;
  logic             w_have_q;
  logic [3:0]       wstrb_q;
  logic [1:0]       rx_sync_q;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_lim;
  logic             tick_q;
  logic             tx_load;
  logic             tx_busy;
  logic             tx_line;
  logic             rx_line;
  logic             rx_busy;
  logic             rx_done;
  logic [7:0]       rx_word;
  logic             rx_serr;
  logic             rx_perr;
  logic             rx_ferr;
  logic             wr_fire;
  logic             rd_fire;
  logic [2:0]       br;
  logic [2:0]       rc;

  // Frame format shared with the engines
  assign fmt.eight_bit = cmd_q[CMD_WL];
  assign fmt.par_en    = cmd_q[CMD_PE];
  assign fmt.par_odd   = cmd_q[CMD_PM];
  assign fmt.tick      = tick_q;
  assign br            = ctrl_q[CTRL_BR +: 3];
  assign rc            = cmd_q[CMD_RC +: 3];

  // Rate scaling: each rate step doubles baud; with XTAL clear, each range step halves it
  always_comb begin
    if (cmd_q[CMD_XTAL])
      div_lim = DIV_W'(XTAL_DIV >> br);
    else
      div_lim = DIV_W'((BASE_DIV << rc) >> br);
  end

  // Oversampling tick generator; rate change applies at once to the count already running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q >= div_lim - DIV_W'(1)) begin
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + DIV_W'(1);
      tick_q <= 1'b0;
    end
  end

  // Two-stage synchroniser on the receive pin
  always_ff @(posedge aclk) begin
    if (!aresetn) rx_sync_q <= 2'b11;
    else          rx_sync_q <= {rx_sync_q[0], rx_pin};
  end

  assign rx_line = rx_sync_q[1] ^ ctrl_q[CTRL_XRX];

  // Line output: echo bypasses the transmitter entirely
  always_ff @(posedge aclk) begin
    if (!aresetn)
      tx_pin <= 1'b1;
    else if (ctrl_q[CTRL_ECHO])
      tx_pin <= rx_sync_q[1] ^ ctrl_q[CTRL_XRX] ^ ctrl_q[CTRL_XTX];
    else if (ctrl_q[CTRL_ENTX])
      tx_pin <= tx_line ^ ctrl_q[CTRL_XTX];
    else
      tx_pin <= ~ctrl_q[CTRL_XTX];  // Idle level when disabled
  end

  // Hand the holding word over once the shifter is free
  assign tx_load = ctrl_q[CTRL_ENTX] && tx_full_q && !tx_busy;

  ast_tx u_tx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fmt     (fmt),
    .load    (tx_load),
    .word    (txd_q),
    .busy    (tx_busy),
    .line    (tx_line)
  );

  ast_rx u_rx (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .fmt       (fmt),
    .enable    (ctrl_q[CTRL_ENRX]),
    .line      (rx_line),
    .busy      (rx_busy),
    .done      (rx_done),
    .word      (rx_word),
    .start_err (rx_serr),
    .par_err   (rx_perr),
    .frame_err (rx_ferr)
  );

  // AXI write channel capture; address and data arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_q      <= '0;
      w_q       <= '0;
      wstrb_q   <= '0;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_q      <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
    end
  end

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

  // Ready flags registered; low while holding or answering
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready)
                       && !s_axi_bvalid;
      s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready)
                       && !s_axi_bvalid;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      case (aw_q & 5'h1C)
        CMD_OFS, CTRL_OFS, TXD_OFS, TXSTA_OFS, RXD_OFS, RXSTA_OFS:
          s_axi_bresp <= RESP_OKAY;
        default: s_axi_bresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_q  <= CMD_RST;
      ctrl_q <= CTRL_RST;
      txd_q  <= 8'h00;
    end else if (wr_fire && wstrb_q[0]) begin
      case (aw_q & 5'h1C)
        CMD_OFS:  cmd_q  <= w_q[7:0];
        CTRL_OFS: ctrl_q <= w_q[7:0];
        TXD_OFS:  txd_q  <= w_q[7:0];
        default: ;
      endcase
    end
  end

  // Transmit full flag; a write in the load cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn)
      tx_full_q <= 1'b0;
    else if (wr_fire && wstrb_q[0] && (aw_q & 5'h1C) == TXD_OFS)
      tx_full_q <= 1'b1;
    else if (tx_load)
      tx_full_q <= 1'b0;
  end

  // Interrupt pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      tx_irq <= tx_load;
      rx_irq <= rx_done;
    end
  end

  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // Receive data and flags; new word beats a same-cycle read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_q     <= 8'h00;
      rx_full_q <= 1'b0;
      serr_q    <= 1'b0;
      perr_q    <= 1'b0;
      ferr_q    <= 1'b0;
    end else if (rx_done) begin
      rxd_q     <= rx_word;
      rx_full_q <= 1'b1;
      serr_q    <= rx_serr;
      perr_q    <= rx_perr;
      ferr_q    <= rx_ferr;
    end else if (rd_fire && (s_axi_araddr & 5'h1C) == RXD_OFS) begin
      rx_full_q <= 1'b0;
    end
  end

  // Overrun: set wins over a status write
  always_ff @(posedge aclk) begin
    if (!aresetn)
      ovr_q <= 1'b0;
    else if (rx_done && rx_full_q &&
             !(rd_fire && (s_axi_araddr & 5'h1C) == RXD_OFS))
      ovr_q <= 1'b1;
    else if (wr_fire && (aw_q & 5'h1C) == RXSTA_OFS)
      ovr_q <= 1'b0;
  end

  // Read channel; one-cycle answer after address acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (s_axi_araddr & 5'h1C)
          CMD_OFS:   s_axi_rdata <= {24'h000000, cmd_q};
          CTRL_OFS:  s_axi_rdata <= {24'h000000, ctrl_q};
          TXD_OFS:   s_axi_rdata <= {24'h000000, txd_q};
          TXSTA_OFS: s_axi_rdata <= {30'h00000000, tx_busy, tx_full_q};
          RXD_OFS:   s_axi_rdata <= {24'h000000, rxd_q};
          RXSTA_OFS: s_axi_rdata <= {26'h0000000, serr_q, perr_q, ferr_q,
                                     ovr_q, rx_busy, rx_full_q};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

/* bench/ast_top_chk.sv */
// Checker for the serial transceiver top: bus answers and irq pulses.
// Assumes it is bound to ast_top and sees only that module's ports.
`timescale 1ns/1ns
module ast_top_chk
  import ast_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [4:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        tx_irq,
  input wire logic        rx_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic ar_go;
  logic bad_ad;
  // Accepted read and whether its offset lies off the map
  assign ar_go  = s_axi_arvalid && s_axi_arready;
  assign bad_ad = s_axi_araddr > 5'h14 || s_axi_araddr[1:0] != 2'h0;

  a_tx_irq_once: assert property (tx_irq |=> !tx_irq [*8])
    else $error("tx_irq longer than one cycle");
  a_rx_irq_once: assert property (rx_irq |=> !rx_irq [*8])
    else $error("rx_irq longer than one cycle");
  a_rd_answer: assert property (ar_go |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_unmapped: assert property (ar_go && bad_ad |=>
      s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_rd_mapped: assert property (ar_go && !bad_ad |=>
      s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 24'h0)
    else $error("mapped read bad response or upper bits");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
      !s_axi_bvalid && !s_axi_rvalid && !tx_irq && !rx_irq)
    else $error("outputs active after reset");
  c_tx: cover property (tx_irq);
  c_rx: cover property (rx_irq);
  c_bad: cover property (ar_go && bad_ad);
endmodule

bind ast_top ast_top_chk i_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_rresp, .tx_irq, .rx_irq);

/* bench/ast_remote.sv */
// Remote serial device: sends frames into rx and decodes frames from tx.
// Assumes the fastest rate setting: rate field 7, range field 0.
`timescale 1ns/1ns
module ast_remote
  import ast_pkg::*;
(
  input wire logic aclk,
  input wire logic from_dut,
  output logic     to_dut
);
  localparam int BIT = (BASE_DIV >> 7) * OVS;
  initial to_dut = 1'b1;

  // Steady line level, also used as idle
  task automatic level(input logic v);
    @(posedge aclk);
    to_dut <= v;
  endtask

  // One frame; bad parity or low stop only on request
  task automatic send(input logic [7:0] d, input int nb,
      input logic pe, odd, bp, bs, inv);
    logic [10:0] f;
    logic p;
    int n;
    f = '1;
    p = odd;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++) begin
      f[i+1] = d[i];
      p ^= d[i];
    end
    n = nb + 1;
    if (pe) begin
      f[n] = p ^ bp;
      n++;
    end
    f[n] = !bs;
    for (int i = 0; i <= n; i++) begin
      level(f[i] ^ inv);
      repeat (BIT - 1) @(posedge aclk);
    end
    level(!inv);
    repeat (2 * BIT) @(posedge aclk); // Idle gap, no back to back
  endtask

  // Decode one frame at bit middles
  task automatic grab(input int nb, input logic pe, inv,
      output logic [7:0] d, output logic p, output logic s);
    d = 8'h00;
    p = 1'b0;
    do @(posedge aclk); while (from_dut !== inv);
    repeat (BIT / 2) @(posedge aclk);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT) @(posedge aclk);
      d[i] = from_dut ^ inv;
    end
    if (pe) begin
      repeat (BIT) @(posedge aclk);
      p = from_dut ^ inv;
    end
    repeat (BIT) @(posedge aclk);
    s = from_dut ^ inv;
  endtask
endmodule

/* bench/async_serial_transceiver_test.sv */
// Self-checking bench for the serial transceiver over AXI4-Lite.
// Assumes the fastest rate setting so one bit lasts 800 clocks.
`timescale 1ns/1ns
module async_serial_transceiver_test;
  import ast_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_pin, tx_pin;
  logic        tx_irq, rx_irq;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  int          n_mismatch, total_checks, n_txi, n_rxi;

  always #4 aclk = ~aclk;
  ast_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_pin, .tx_pin,
    .tx_irq, .rx_irq);
  ast_remote i_rem (.aclk, .from_dut(tx_pin), .to_dut(rx_pin));

  // Interrupt pulse counters
  always @(posedge aclk) begin
    if (tx_irq === 1'b1) n_txi++;
    if (rx_irq === 1'b1) n_rxi++;
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h got %h", nm, e, g);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Bus write: aw and w together, each dropped when taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [4:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [4:0] a,
      input logic [31:0] m, e);
    rdr(a);
    chk(nm, e, rd & m);
  endtask

  task automatic t_reset;
    logic [31:0] rv [6] = '{32'h01, 32'h05, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++) begin
      rchk("reset value", 5'(4 * i), 32'hFFFFFFFF, rv[i]);
    end
    rdr(5'h18);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(resp));
    wr(5'h1C, 32'hFF);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(resp));
  endtask

  // Echo with three invert pairings (never both clear), receiver left off
  task automatic t_echo;
    logic [7:0] c [3] = '{8'h9F, 8'h8F, 8'h97};
    int n0;
    n0 = n_rxi;
    for (int i = 0; i < 3; i++) begin
      wr(CTRL_OFS, 32'(c[i]));
      for (int v = 0; v < 2; v++) begin
        i_rem.level(v[0]);
        repeat (8) @(posedge aclk); // Sync and output register margin
        chk("echo", 32'(v[0] ^ c[i][4] ^ c[i][3]), 32'(tx_pin));
      end
    end
    chk("rx off irq", n0, n_rxi);
  endtask

  task automatic t_tx(input logic [7:0] cmd, ctl, d);
    logic [7:0] g, m;
    logic p, s, inv;
    int n0;
    m = cmd[CMD_WL] ? 8'hFF : 8'h7F;
    inv = ctl[CTRL_XTX];
    wr(CMD_OFS, 32'(cmd));
    wr(CTRL_OFS, 32'(ctl & 8'hDF));
    wr(TXD_OFS, 32'(d));
    rchk("tx full", TXSTA_OFS, 32'hFF, 32'h01);
    n0 = n_txi;
    fork
      i_rem.grab(cmd[CMD_WL] ? 8 : 7, cmd[CMD_PE], inv, g, p, s);
      begin
        wr(CTRL_OFS, 32'(ctl));
        rchk("tx busy", TXSTA_OFS, 32'hFF, 32'h02);
      end
    join
    chk("tx data", 32'(d & m), 32'(g));
    chk("tx parity", 32'(^(d & m) ^ cmd[CMD_PM]), 32'(p));
    chk("tx stop", 32'h1, 32'(s));
    chk("tx irq count", n0 + 1, n_txi);
    repeat (i_rem.BIT) @(posedge aclk);
    rchk("tx done", TXSTA_OFS, 32'hFF, 32'h0);
    chk("tx idle level", 32'(!inv), 32'(tx_pin));
  endtask

  task automatic t_rx(input logic [7:0] d, input int nb,
      input logic pe, odd, bp, bs, inv, input logic [31:0] m, e);
    int n0;
    n0 = n_rxi;
    i_rem.send(d, nb, pe, odd, bp, bs, inv);
    chk("rx irq count", n0 + 1, n_rxi);
    rchk("rx status", RXSTA_OFS, m, e);
  endtask

  task automatic t_rx_all;
    wr(CMD_OFS, 32'h07);
    wr(CTRL_OFS, 32'h47);
    t_rx(8'h3C, 8, 1, 1, 0, 0, 0, 32'h3D, 32'h01);
    rchk("rx data", RXD_OFS, 32'hFF, 32'h3C);
    rchk("rx read clears", RXSTA_OFS, 32'h01, 32'h0);
    t_rx(8'h81, 8, 1, 1, 1, 0, 0, 32'h35, 32'h11);
    t_rx(8'h42, 8, 1, 1, 0, 1, 0, 32'h3D, 32'h0D);
    rchk("rx overwrite", RXD_OFS, 32'hFF, 32'h42);
    rchk("overrun held", RXSTA_OFS, 32'h05, 32'h04);
    wr(RXSTA_OFS, 32'h0);
    rchk("overrun clear", RXSTA_OFS, 32'h05, 32'h0);
    // Low stop bit leaves the line low, so the receiver rearms on it
    repeat (10 * i_rem.BIT) @(posedge aclk);
    rchk("rx rearm status", RXSTA_OFS, 32'h1D, 32'h01);
    rchk("rx rearm data", RXD_OFS, 32'hFF, 32'hFF);
    // Inverted line must idle low before the receiver wakes
    wr(CMD_OFS, 32'h0);
    wr(CTRL_OFS, 32'h17);
    i_rem.level(1'b0);
    wr(CTRL_OFS, 32'h57);
    fork
      t_rx(8'hB5, 7, 0, 0, 0, 0, 1, 32'h35, 32'h01);
      begin
        repeat (3 * i_rem.BIT) @(posedge aclk);
        rchk("rx busy", RXSTA_OFS, 32'h02, 32'h02);
      end
    join
    rchk("rx seven bit", RXD_OFS, 32'hFF, 32'h35);
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 5'h00;
    s_axi_araddr = 5'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_echo;
    t_tx(8'h07, 8'h27, 8'hA5);
    t_tx(8'h02, 8'h2F, 8'hD3);
    t_rx_all;
    end_sim;
  end

  // Watchdog sized above the six frames plus bus traffic
  initial begin
    repeat (90000) @(posedge aclk);
    n_mismatch++;
    $display("[ERR] watchdog expected done got timeout");
    end_sim;
  end
endmodule
